/* File: srn_pkg.sv */
// Constants and types for the symbol-rate oscillator and its tracking loop.
// Assumes one 100 MHz clock and configuration ports held steady by software.
// Behaviour
// - Symbol oscillator is a 32-bit phase accumulator whose carry marks symbol events.
// - Each cycle outside counter mode the accumulator adds the base step plus the loop correction; counter mode holds it at zero.
// - A control bit gates the loop correction; when off the loop has no influence.
// - A clock at twice the symbol rate is driven on its own output pin.
// - Counter mode makes symbol clocks at a 16-bit rollover count instead.
// - Base step is scaled by the interpolating filter's input rate multiplier.
// - Reference divides by its programmed value, symbol divider by value plus one.
// - Reference divider carry samples accumulator phase as the phase error.
// - Frequency error is current minus previous phase error; both feed the filter.
// - Loop filter runs at half rate, 32 of its cycles per error pair.
// - Lag accumulator integrates phase error times lag gain plus frequency term.
// - Lag accumulator is forced to the upper or lower limit when exceeded.
// - Filter output is lag accumulator plus phase error times lead gain.
// - Gain is binary 01.MMMM times 2 to the power exponent minus 17.
// - Phase error magnitude at or over threshold adds negative addend, else positive.
// - Lock integrator resets to its full-scale negative value.
// - Lock flag is the inverted integrator sign bit, driven on a pin.
// - Lock factor picks negative addend by upper bit, positive by lower two bits.
// - Changes of lock status are offered as an event for an interrupt.
package srn_pkg;
    localparam int unsigned PHASE_WIDTH  = 32;
    localparam int unsigned COUNT_WIDTH  = 16;
    localparam int unsigned DIV_WIDTH    = 16;
    localparam int unsigned THRESH_WIDTH = 21;
    localparam int unsigned LOCK_WIDTH   = 8;
    localparam int unsigned SCALE_BITS   = 5;
    localparam int unsigned DBL_CLK_BASE = 30;
    localparam int          GAIN_EXP_BIAS = 17;
    localparam int          GAIN_MANT_BITS = 4;
    localparam logic [5:0]  GAIN_LEAD_ONE = 6'h10;
    localparam logic [4:0]  FILTER_LAST   = 5'h1F;
    localparam logic [7:0]  LOCK_RESET    = 8'h80;
    localparam logic [7:0]  LOCK_MAX      = 8'h7F;
    localparam logic [7:0]  ADD_NEG_HALF  = 8'hF8;
    localparam logic [7:0]  ADD_NEG_QUART = 8'hFC;
    localparam logic [7:0]  ADD_POS_BASE  = 8'h01;

    typedef enum logic [1:0] {
        INTERP_X2  = 2'b00,
        INTERP_X4  = 2'b01,
        INTERP_X8  = 2'b10,
        INTERP_X16 = 2'b11
    } srn_interp_type;

    typedef enum logic {
        FILTER_IDLE = 1'b0,
        FILTER_BUSY = 1'b1
    } srn_filter_state_type;

    typedef struct packed {
        logic [3:0] mantissa;
        logic [4:0] exponent;
    } srn_gain_type;

    typedef struct packed {
        logic           fir_bypass;
        srn_interp_type fir_interp;
        logic           halfband_bypass;
    } srn_filter_cfg_type;

    typedef struct packed {
        srn_gain_type       lead;
        srn_gain_type       lag;
        srn_gain_type       freq;
        logic signed [31:0] upper_limit;
        logic signed [31:0] lower_limit;
    } srn_loop_cfg_type;

    typedef struct packed {
        logic [20:0] threshold;
        logic [2:0]  factor;
    } srn_lock_cfg_type;
endpackage : srn_pkg

/* File: srn_symbol_nco.sv */
// Symbol-rate oscillator, reference dividers, lead/lag loop filter and lock detector.
// Assumes all inputs are synchronous to i_clock and configuration changes rarely.
`timescale 1ns/100ps
module srn_symbol_nco
    import srn_pkg::*;
(
    input  wire logic                      i_clock,
    input  wire logic                      i_reset,
    input  wire logic                      i_clock_enable,
    input  wire logic [PHASE_WIDTH-1:0]    i_base_phase_step,
    input  wire logic                      i_tracking_enable,
    input  wire logic                      i_counter_mode,
    input  wire logic [COUNT_WIDTH-1:0]    i_rollover_count,
    input  wire srn_filter_cfg_type        i_filter_cfg,
    input  wire logic                      i_external_symbol_reference,
    input  wire logic [DIV_WIDTH-1:0]      i_reference_divider,
    input  wire logic [DIV_WIDTH-1:0]      i_symbol_divider,
    input  wire srn_loop_cfg_type          i_loop_cfg,
    input  wire srn_lock_cfg_type          i_lock_cfg,
    output logic                           o_symbol_strobe,
    output logic                           o_double_rate_symbol_clock_out,
    output logic                           o_divided_symbol_strobe,
    output logic signed [PHASE_WIDTH-1:0]  o_sampled_phase_error,
    output logic signed [PHASE_WIDTH:0]    o_frequency_error_term,
    output logic signed [PHASE_WIDTH-1:0]  o_loop_correction,
    output logic                           o_lock_flag,
    output logic                           o_lock_event
);

    // Scales an error by 01.MMMM * 2^(E-17), keeping 64 bits of headroom.
    function automatic logic signed [63:0] apply_gain(input logic signed [32:0] err,
                                                      input srn_gain_type    g);
        logic signed [63:0] prod;
        int                 shift;
        prod  = 64'(err) * $signed({58'h0, GAIN_LEAD_ONE | {2'b00, g.mantissa}});
        shift = int'(g.exponent) - GAIN_EXP_BIAS - GAIN_MANT_BITS;
        if (shift >= 0) begin
            apply_gain = prod <<< shift;
        end else begin
            apply_gain = prod >>> (-shift);
        end
    endfunction : apply_gain

    logic [PHASE_WIDTH-1:0]       acc;
    logic [SCALE_BITS-1:0]        carry_count;
    logic [COUNT_WIDTH-1:0]       roll_count;
    logic                         ref_prev;
    logic [DIV_WIDTH-1:0]         ref_count;
    logic [DIV_WIDTH-1:0]         sym_count;
    logic                         half_phase;
    srn_filter_state_type         filter_state;
    logic [4:0]                   filter_count;
    logic signed [31:0]           filter_pe;
    logic signed [32:0]           filter_fe;
    logic signed [31:0]           lag_acc;
    logic [LOCK_WIDTH-1:0]        lock_int;

    // Step scaling to the interpolating filter input rate.
    wire logic [2:0] fir_shift = 3'(i_filter_cfg.fir_interp) + 3'h1;
    wire logic [2:0] hb_shift  = i_filter_cfg.halfband_bypass ? 3'h0 : 3'h1;
    wire logic [2:0] step_shift = i_filter_cfg.fir_bypass ? hb_shift
                                                           : fir_shift + hb_shift;
    wire logic [PHASE_WIDTH-1:0] scaled_step = i_base_phase_step << step_shift;
    wire logic [PHASE_WIDTH-1:0] loop_term =
        i_tracking_enable ? o_loop_correction : '0;
    wire logic [PHASE_WIDTH-1:0] step_total = scaled_step + loop_term;
    wire logic [PHASE_WIDTH:0] acc_sum = {1'b0, acc} + {1'b0, step_total};
    wire logic nco_carry = acc_sum[PHASE_WIDTH];

    // One symbol per 2^shift accumulator carries.
    wire logic [SCALE_BITS-1:0] scale_mask = SCALE_BITS'((6'h01 << step_shift) - 6'h01);
    wire logic nco_symbol = nco_carry && ((carry_count & scale_mask) == scale_mask);
    wire logic roll_hit = (roll_count >= i_rollover_count);
    wire logic sym_tick = i_counter_mode ? roll_hit : nco_symbol;

    // Twice-symbol-rate square wave from the extended phase or the rollover count.
    wire logic [PHASE_WIDTH+SCALE_BITS-1:0] ext_phase = {carry_count, acc};
    wire logic [5:0] dbl_index = 6'(DBL_CLK_BASE) + {3'h0, step_shift};
    wire logic [COUNT_WIDTH-1:0] roll_half = i_rollover_count >> 1;
    wire logic [COUNT_WIDTH-1:0] roll_quart = i_rollover_count >> 2;
    wire logic roll_dbl = (roll_count < roll_quart) ||
                          ((roll_count >= roll_half) && (roll_count < roll_half + roll_quart));
    wire logic next_dbl_clock = i_counter_mode ? roll_dbl : ext_phase[dbl_index];

    // Reference and symbol dividers.
    wire logic ref_edge = i_external_symbol_reference && !ref_prev;
    wire logic [DIV_WIDTH:0] ref_next_count = {1'b0, ref_count} + 17'h00001;
    wire logic ref_carry = ref_edge && (ref_next_count >= {1'b0, i_reference_divider});
    wire logic sym_carry = sym_tick && (sym_count >= i_symbol_divider);

    // Error terms taken at the reference carry.
    wire logic signed [31:0] sample_pe = $signed(acc);
    wire logic signed [32:0] sample_fe = 33'(sample_pe) - 33'(o_sampled_phase_error);

    // Loop filter arithmetic, committed at the end of the 32 slow cycles.
    wire logic filter_start = ref_carry && (filter_state == FILTER_IDLE);
    wire logic slow_tick = half_phase;
    wire logic filter_done = (filter_state == FILTER_BUSY) && slow_tick &&
                             (filter_count == FILTER_LAST);
    wire logic signed [63:0] lag_sum = 64'(lag_acc) +
                                       apply_gain(33'(filter_pe), i_loop_cfg.lag) +
                                       apply_gain(filter_fe, i_loop_cfg.freq);
    wire logic over_upper = lag_sum > 64'(i_loop_cfg.upper_limit);
    wire logic under_lower = lag_sum < 64'(i_loop_cfg.lower_limit);
    wire logic signed [31:0] next_lag = over_upper  ? i_loop_cfg.upper_limit :
                                        under_lower ? i_loop_cfg.lower_limit :
                                                      lag_sum[31:0];
    wire logic signed [63:0] corr_sum = 64'(next_lag) +
                                        apply_gain(33'(filter_pe), i_loop_cfg.lead);
    wire logic signed [31:0] next_correction = corr_sum[31:0];

    // Lock detector on the freshly sampled phase error.
    wire logic [32:0] pe_mag = sample_pe[31] ? 33'(-33'(sample_pe)) : 33'(sample_pe);
    wire logic over_thresh = pe_mag >= {12'h000, i_lock_cfg.threshold};
    wire logic [7:0] neg_addend = i_lock_cfg.factor[2] ? ADD_NEG_QUART
                                                       : ADD_NEG_HALF;
    wire logic [7:0] pos_addend = ADD_POS_BASE << i_lock_cfg.factor[1:0];
    wire logic [7:0] lock_addend = over_thresh ? neg_addend : pos_addend;
    wire logic signed [8:0] lock_sum = $signed({lock_int[7], lock_int}) +
                                       $signed({lock_addend[7], lock_addend});
    wire logic [7:0] next_lock_int = (lock_sum > 9'sh07F) ? LOCK_MAX :
                                     (lock_sum < -9'sh080) ? LOCK_RESET :
                                     lock_sum[7:0];
    wire logic [7:0] lock_now = ref_carry ? next_lock_int : lock_int;
    wire logic next_lock_flag = !lock_now[7];

    // Symbol oscillator state.
    always_ff @(posedge i_clock or posedge i_reset) begin
        if (i_reset) begin
            acc         <= '0;
            carry_count <= '0;
            roll_count  <= '0;
        end else if (i_clock_enable) begin
            acc <= i_counter_mode ? '0 : acc_sum[PHASE_WIDTH-1:0];
            carry_count <= (!i_counter_mode && nco_carry) ? carry_count + 5'h01 : carry_count;
            roll_count  <= (!i_counter_mode || roll_hit) ? '0 : roll_count + 16'h0001;
        end
    end

    // Clock outputs.
    always_ff @(posedge i_clock or posedge i_reset) begin
        if (i_reset) begin
            o_symbol_strobe                <= 1'b0;
            o_double_rate_symbol_clock_out <= 1'b0;
            o_divided_symbol_strobe        <= 1'b0;
        end else if (i_clock_enable) begin
            o_symbol_strobe                <= sym_tick;
            o_double_rate_symbol_clock_out <= next_dbl_clock;
            o_divided_symbol_strobe        <= sym_carry;
        end
    end

    // Dividers.
    always_ff @(posedge i_clock or posedge i_reset) begin
        if (i_reset) begin
            ref_prev  <= 1'b0;
            ref_count <= '0;
            sym_count <= '0;
        end else if (i_clock_enable) begin
            ref_prev <= i_external_symbol_reference;
            if (ref_edge) begin
                ref_count <= ref_carry ? '0 : ref_next_count[DIV_WIDTH-1:0];
            end
            if (sym_tick) begin
                sym_count <= sym_carry ? '0 : sym_count + 16'h0001;
            end
        end
    end

    // Error detector.
    always_ff @(posedge i_clock or posedge i_reset) begin
        if (i_reset) begin
            o_sampled_phase_error  <= '0;
            o_frequency_error_term <= '0;
        end else if (i_clock_enable && ref_carry) begin
            o_sampled_phase_error  <= sample_pe;
            o_frequency_error_term <= sample_fe;
        end
    end

    // Loop filter sequencer; a pair arriving while busy is skipped by the filter.
    always_ff @(posedge i_clock or posedge i_reset) begin
        if (i_reset) begin
            half_phase   <= 1'b0;
            filter_state <= FILTER_IDLE;
            filter_count <= '0;
            filter_pe    <= '0;
            filter_fe    <= '0;
        end else if (i_clock_enable) begin
            half_phase <= !half_phase;
            case (filter_state)
                FILTER_IDLE: begin
                    filter_count <= '0;
                    if (filter_start) begin
                        filter_pe    <= sample_pe;
                        filter_fe    <= sample_fe;
                        filter_state <= FILTER_BUSY;
                    end
                end
                FILTER_BUSY: begin
                    if (slow_tick) begin
                        filter_count <= filter_count + 5'h01;
                        if (filter_done) begin
                            filter_state <= FILTER_IDLE;
                        end
                    end
                end
                default: begin
                    filter_state <= FILTER_IDLE;
                end
            endcase
        end
    end

    // Loop filter results.
    always_ff @(posedge i_clock or posedge i_reset) begin
        if (i_reset) begin
            lag_acc           <= '0;
            o_loop_correction <= '0;
        end else if (i_clock_enable && filter_done) begin
            lag_acc           <= next_lag;
            o_loop_correction <= next_correction;
        end
    end

    // Lock integrator and flag.
    always_ff @(posedge i_clock or posedge i_reset) begin
        if (i_reset) begin
            lock_int     <= LOCK_RESET;
            o_lock_flag  <= 1'b0;
            o_lock_event <= 1'b0;
        end else if (i_clock_enable) begin
            lock_int     <= lock_now;
            o_lock_flag  <= next_lock_flag;
            o_lock_event <= next_lock_flag != o_lock_flag;
        end
    end

    chk_track_gate: assert property (@(posedge i_clock) disable iff (i_reset)
        !i_tracking_enable |-> step_total == scaled_step)
        else $error("Correction added while tracking disabled.");

    chk_step_scale: assert property (@(posedge i_clock) disable iff (i_reset)
        (!i_filter_cfg.fir_bypass && i_filter_cfg.fir_interp == INTERP_X16 &&
         !i_filter_cfg.halfband_bypass) |-> scaled_step == (i_base_phase_step << 5))
        else $error("Step not scaled by 32.");

    chk_acc_update: assert property (@(posedge i_clock) disable iff (i_reset)
        (i_clock_enable && !i_counter_mode) ##1 !i_counter_mode
        |-> acc == $past(acc) + $past(scaled_step) + $past(loop_term))
        else $error("Accumulator did not add the step.");

    chk_sample_phase: assert property (@(posedge i_clock) disable iff (i_reset)
        (i_clock_enable && ref_carry) |=> o_sampled_phase_error == $signed($past(acc)))
        else $error("Phase not sampled at reference carry.");

    chk_freq_error: assert property (@(posedge i_clock) disable iff (i_reset)
        (i_clock_enable && ref_carry) |=> o_frequency_error_term ==
        33'($signed($past(acc))) - 33'($past(o_sampled_phase_error)))
        else $error("Frequency error is not a phase difference.");

    chk_filter_span: assert property (@(posedge i_clock) disable iff (i_reset)
        filter_done |-> filter_count == FILTER_LAST && half_phase)
        else $error("Filter finished before 32 slow cycles.");

    chk_lag_limits: assert property (@(posedge i_clock) disable iff (i_reset)
        (i_clock_enable && filter_done &&
         i_loop_cfg.lower_limit <= i_loop_cfg.upper_limit) |=>
        lag_acc <= $past(i_loop_cfg.upper_limit) && lag_acc >= $past(i_loop_cfg.lower_limit))
        else $error("Lag accumulator outside its limits.");

    chk_lock_flag: assert property (@(posedge i_clock) disable iff (i_reset)
        i_clock_enable |=> o_lock_flag == !lock_int[7])
        else $error("Lock flag does not follow integrator sign.");

    chk_lock_saturate: assert property (@(posedge i_clock) disable iff (i_reset)
        (i_clock_enable && ref_carry && lock_int == LOCK_MAX && !over_thresh)
        |=> lock_int == LOCK_MAX)
        else $error("Lock integrator wrapped at the top.");

    cov_lock_gained: cover property (@(posedge i_clock) disable iff (i_reset)
        $rose(o_lock_flag));
    cov_filter_done: cover property (@(posedge i_clock) disable iff (i_reset)
        filter_done && i_tracking_enable);
    cov_counter_symbol: cover property (@(posedge i_clock) disable iff (i_reset)
        i_counter_mode && sym_tick);

endmodule : srn_symbol_nco

/* File: srn_reference_source.sv */
// Behavioural source of the external symbol reference clock.
// Assumes the bench clock and a run level; while run is low the reference stays low.
`timescale 1ns/100ps
module srn_reference_source (
    input  wire logic       i_clock,
    input  wire logic       i_run,
    input  wire logic [7:0] i_half_period,
    output logic            o_reference
);
    logic [7:0] count;

    initial begin
        o_reference = 1'b0;
        count       = 8'h00;
    end

    // The reference toggles every half period, changed just after the rising edge.
    always @(posedge i_clock) begin
        #1;
        if (!i_run) begin
            count       = 8'h00;
            o_reference = 1'b0;
        end else if (count == i_half_period - 8'h01) begin
            count       = 8'h00;
            o_reference = !o_reference;
        end else begin
            count = count + 8'h01;
        end
    end
endmodule : srn_reference_source

/* File: srn_symbol_nco_tb_top.sv */
// Self-checking bench for the symbol oscillator, counter mode and lock detector.
// Assumes a 100 MHz clock; inputs change 1 to 3 ns after the rising edge.
`timescale 1ns/100ps
`define CHK(what, exp, got) begin tests_run++; if ((got) !== (exp)) begin n_errors++; \
    $display("CHECK FAILED %s expected %0h seen %0h", what, exp, got); end end
module srn_symbol_nco_tb_top;
    import srn_pkg::*;
    logic                     i_clock = 1'b0;
    logic                     i_reset = 1'b1;
    logic [PHASE_WIDTH-1:0]   base = 32'h04000000;
    logic                     counter_mode = 1'b0;
    logic [COUNT_WIDTH-1:0]   rollover = 16'h0003;
    srn_filter_cfg_type       filter_cfg = '0;
    logic                     run = 1'b0;
    logic                     reference;
    logic [DIV_WIDTH-1:0]     ref_div = 16'h0004;
    srn_lock_cfg_type         lock_cfg = '0;
    logic                     strobe, dbl, lock_flag, lock_event, vstrobe;
    logic signed [PHASE_WIDTH-1:0] pe, corr;
    logic signed [PHASE_WIDTH:0]   fe;
    int n_errors = 0, tests_run = 0, n_events = 0;

    initial begin
        forever #5 i_clock = !i_clock;
    end

    srn_reference_source ref_src (.i_clock(i_clock), .i_run(run), .i_half_period(8'h04),
        .o_reference(reference));

    srn_symbol_nco uut (.i_clock(i_clock), .i_reset(i_reset), .i_clock_enable(1'b1),
        .i_base_phase_step(base), .i_tracking_enable(1'b0), .i_counter_mode(counter_mode),
        .i_rollover_count(rollover), .i_filter_cfg(filter_cfg),
        .i_external_symbol_reference(reference), .i_reference_divider(ref_div),
        .i_symbol_divider(16'h0004), .i_loop_cfg('0), .i_lock_cfg(lock_cfg),
        .o_symbol_strobe(strobe), .o_double_rate_symbol_clock_out(dbl),
        .o_divided_symbol_strobe(vstrobe), .o_sampled_phase_error(pe),
        .o_frequency_error_term(fe), .o_loop_correction(corr), .o_lock_flag(lock_flag),
        .o_lock_event(lock_event));

    always @(posedge i_clock) begin
        #2;
        if (lock_event === 1'b1) n_events++;
    end

    task automatic stop_test();
        $display("Checks made %0d, mismatches %0d", tests_run, n_errors);
        if (n_errors == 0 && tests_run > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : stop_test

    task automatic apply_reset();
        @(posedge i_clock);
        #1 i_reset = 1'b1;
        run = 1'b0;
        repeat (2) @(posedge i_clock);
        #1 i_reset = 1'b0;
        run = 1'b1;
    endtask : apply_reset

    task automatic wait_cycles(input int cycles);
        repeat (cycles) @(posedge i_clock);
        #2;
    endtask : wait_cycles

    // Counts symbol strobes and double clock rises over a number of cycles after reset.
    task automatic count_run(input int cycles, input int exp_s, input int exp_d,
                             input int exp_v);
        int ns, nd, nv;
        logic prev;
        nv = 0;
        ns = 0;
        nd = 0;
        prev = 1'b0;
        apply_reset();
        repeat (cycles) begin
            @(posedge i_clock);
            #2;
            if (strobe === 1'b1) ns++;
            if (vstrobe === 1'b1) nv++;
            if (dbl === 1'b1 && prev === 1'b0) nd++;
            prev = dbl;
        end
        `CHK("symbol strobes", exp_s, ns)
        `CHK("divided symbol strobes", exp_v, nv)
        if (exp_d > 0) `CHK("double clock rises", exp_d, nd)
    endtask : count_run

    initial begin
        #900_000;
        n_errors++;
        $display("CHECK FAILED run length expected end seen hang");
        stop_test();
    end

    initial begin
        repeat (2) @(posedge i_clock);
        #1;
        `CHK("lock flag in reset", 1'b0, lock_flag)
        `CHK("strobe in reset", 1'b0, strobe)
        // Base step of 2^26 gives one symbol each 64 cycles for every filter setting.
        for (int i = 0; i < 16; i++) begin
            filter_cfg = srn_filter_cfg_type'(i[3:0]);
            count_run(650, 10, 20, 2);
        end
        counter_mode = 1'b1;
        rollover = 16'h0003;
        count_run(42, 10, 0, 2);
        rollover = 16'h000F;
        count_run(66, 4, 0, 0);
        // Counter mode holds the accumulator at zero, so every sample is below a threshold of 16 and at or over a threshold of zero.
        rollover = 16'h003F;
        lock_cfg = '{threshold: 21'h000010, factor: 3'b011};
        n_events = 0;
        apply_reset();
        wait_cycles(494);
        `CHK("phase error sample", 32'h00000000, pe)
        `CHK("frequency error term", 33'h000000000, fe)
        `CHK("loop correction", 32'h00000000, corr)
        `CHK("lock before sixteen carries", 1'b0, lock_flag)
        wait_cycles(36);
        `CHK("lock after sixteen carries", 1'b1, lock_flag)
        #1 lock_cfg.threshold = 21'h000000;
        wait_cycles(70);
        `CHK("lock lost at zero threshold", 1'b0, lock_flag)
        `CHK("lock events", 2, n_events)
        #1 lock_cfg.threshold = 21'h000010;
        wait_cycles(600);
        `CHK("lock held at saturation", 1'b1, lock_flag)
        `CHK("lock events after regain", 3, n_events)
        stop_test();
    end
endmodule : srn_symbol_nco_tb_top
